/* rtl/pds_sequencer.sv */
// Input-drop and restart power sequencer with an AHB-Lite register slave.
`timescale 1ns/1ps
module pds_sequencer #(
    parameter int RANK_CYCLES = pds_pkg::RANK_CYCLES,
    parameter int LOAD_CYCLES = pds_pkg::LOAD_CYCLES,
    parameter int CHECK_CYCLES = pds_pkg::CHECK_CYCLES
) (
    // Clock and bus reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Comparators and stored settings
    input wire logic input_ok,
    input wire logic input_por_ok,
    input wire logic nvm_intact,
    input wire logic nvm_auto_turn_on,
    // Processor pins
    input wire logic main_power_request,
    input wire logic cpu_power_request,
    input wire logic cpu_domain_reset_out,
    output logic pmic_reset_out_n,
    // Rail controls
    output pds_pkg::pds_rails_t rail_en,
    output pds_pkg::pds_rails_t discharge_en
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int MAX_CNT = (1 << pds_pkg::TIMER_W) - 1;
    if (RANK_CYCLES < 1 || RANK_CYCLES > MAX_CNT ||
        LOAD_CYCLES < 1 || LOAD_CYCLES > MAX_CNT ||
        CHECK_CYCLES < 1 || CHECK_CYCLES > MAX_CNT) begin : g_bad_count
        $error("Step counts must fit the step timer.");
    end

    localparam pds_pkg::pds_count_t RANK_T =
        pds_pkg::pds_count_t'(RANK_CYCLES);
    localparam pds_pkg::pds_count_t LOAD_T =
        pds_pkg::pds_count_t'(LOAD_CYCLES);
    localparam pds_pkg::pds_count_t CHECK_T =
        pds_pkg::pds_count_t'(CHECK_CYCLES);

    // ------------------------------------------------------------------
    // Sequencer reset and input synchronisers
    // ------------------------------------------------------------------
    logic por_rst_n;
    logic rst_meta;
    logic seq_rst_n;
    logic [5:0] in_meta;
    logic [5:0] in_sync;
    wire logic vin_ok;
    wire logic nvm_ok;
    wire logic auto_on;

    // The POR comparator clears the sequencer at once; release is synced.
    assign por_rst_n = hresetn & input_por_ok;

    // Two-stage release so the sequencer leaves reset on a clean edge.
    always_ff @(posedge hclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            rst_meta <= 1'b0;
            seq_rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            seq_rst_n <= rst_meta;
        end
    end

    // Pins are asynchronous to hclk, so each passes two flip-flops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_meta <= 6'h00;
            in_sync <= 6'h00;
        end else begin
            in_meta <= {cpu_domain_reset_out, cpu_power_request,
                main_power_request, nvm_auto_turn_on, nvm_intact, input_ok};
            in_sync <= in_meta;
        end
    end

    assign vin_ok = in_sync[0];
    assign nvm_ok = in_sync[1];
    assign auto_on = in_sync[2];

    // ------------------------------------------------------------------
    // Step functions
    // ------------------------------------------------------------------
    // Rails held on by the sequence itself in a given state.
    function automatic pds_pkg::pds_rails_t rails_for(
        input pds_pkg::pds_state_t s);
        case (s)
            pds_pkg::S_UP1: rails_for = pds_pkg::STEP1_MASK;
            pds_pkg::S_UP2: rails_for = pds_pkg::STEP2_MASK;
            pds_pkg::S_UP3: rails_for = pds_pkg::STEP3_MASK;
            pds_pkg::S_UP4: rails_for = pds_pkg::STEP4_MASK;
            pds_pkg::S_UP5: rails_for = pds_pkg::STEP5_MASK;
            pds_pkg::S_RUN: rails_for = pds_pkg::STEP5_MASK;
            pds_pkg::S_DOWN0: rails_for = pds_pkg::STEP5_MASK;
            pds_pkg::S_DOWN5: rails_for = pds_pkg::STEP4_MASK;
            pds_pkg::S_DOWN4: rails_for = pds_pkg::STEP3_MASK;
            pds_pkg::S_DOWN3: rails_for = pds_pkg::STEP2_MASK;
            pds_pkg::S_DOWN2: rails_for = pds_pkg::STEP1_MASK;
            default: rails_for = '0;
        endcase
    endfunction : rails_for

    // Length of the step that a state runs for.
    function automatic pds_pkg::pds_count_t dur_for(
        input pds_pkg::pds_state_t s);
        case (s)
            pds_pkg::S_LOAD: dur_for = LOAD_T;
            pds_pkg::S_CHECK: dur_for = CHECK_T;
            default: dur_for = RANK_T;
        endcase
    endfunction : dur_for

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    pds_pkg::pds_state_t state;
    pds_pkg::pds_state_t next_state;
    logic step_done;
    logic dis_armed;
    logic fresh;
    wire logic next_armed;
    wire logic step_start;
    pds_pkg::pds_rails_t ctrl;
    pds_pkg::pds_rails_t next_ctrl;
    pds_pkg::pds_rails_t next_rails;
    pds_pkg::pds_rails_t next_disch;

    pds_step_timer #(
        .W(pds_pkg::TIMER_W)
    ) u_timer (
        .clk(hclk),
        .rst_n(seq_rst_n),
        .start(step_start),
        .cycles(dur_for(next_state)),
        .done(step_done)
    );

    // Each state change reloads the step timer with the new step's length.
    // The first cycle out of reset loads the load step, which no state
    // change marks; without it the load step would never end.
    assign step_start = fresh || (next_state != state);

    // Transition logic; a drop of input-ok aborts power-up or running.
    always_comb begin
        next_state = state;
        case (state)
            pds_pkg::S_LOAD: begin
                if (step_done) begin
                    next_state = (nvm_ok && auto_on) ? pds_pkg::S_CHECK
                        : pds_pkg::S_HALT;
                end
            end
            pds_pkg::S_CHECK: begin
                if (step_done) begin
                    next_state = pds_pkg::S_WAIT;
                end
            end
            pds_pkg::S_WAIT: begin
                if (vin_ok) begin
                    next_state = pds_pkg::S_UP1;
                end
            end
            pds_pkg::S_UP1, pds_pkg::S_UP2, pds_pkg::S_UP3,
            pds_pkg::S_UP4: begin
                if (!vin_ok) begin
                    next_state = pds_pkg::S_DOWN0;
                end else if (step_done) begin
                    next_state = pds_pkg::pds_state_t'(state + 5'h01);
                end
            end
            pds_pkg::S_UP5: begin
                if (!vin_ok) begin
                    next_state = pds_pkg::S_DOWN0;
                end else if (step_done) begin
                    next_state = pds_pkg::S_RUN;
                end
            end
            pds_pkg::S_RUN: begin
                if (!vin_ok) begin
                    next_state = pds_pkg::S_DOWN0;
                end
            end
            pds_pkg::S_DOWN0, pds_pkg::S_DOWN5, pds_pkg::S_DOWN4,
            pds_pkg::S_DOWN3, pds_pkg::S_DOWN2: begin
                if (step_done) begin
                    next_state = pds_pkg::pds_state_t'(state + 5'h01);
                end
            end
            pds_pkg::S_DOWN1: begin
                if (step_done) begin
                    next_state = pds_pkg::S_OFF;
                end
            end
            pds_pkg::S_OFF: begin
                if (vin_ok) begin
                    next_state = pds_pkg::S_CHECK;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
    end

    // Outputs follow next_state so they change on the same edge as state.
    assign next_rails = rails_for(next_state)
        | ((next_state == pds_pkg::S_RUN) ? (ctrl & pds_pkg::SW_MASK)
        : pds_pkg::pds_rails_t'(0));
    assign next_armed = dis_armed || (next_state == pds_pkg::S_CHECK);
    assign next_disch = next_armed ? ~next_rails : '0;

    // Internal reset drops every rail and every discharge at once.
    always_ff @(posedge hclk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            state <= pds_pkg::S_LOAD;
            dis_armed <= 1'b0;
            fresh <= 1'b1;
            rail_en <= '0;
            discharge_en <= '0;
            pmic_reset_out_n <= 1'b0;
        end else begin
            state <= next_state;
            dis_armed <= next_armed;
            fresh <= 1'b0;
            rail_en <= next_rails;
            discharge_en <= next_disch;
            // Only the running state lets the processor out of reset.
            pmic_reset_out_n <= (next_state == pds_pkg::S_RUN);
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------------
    logic dp_write;
    logic [31:0] dp_addr;
    wire logic take;
    wire logic mapped;
    wire logic [31:0] rd_val;
    pds_pkg::pds_status_t status;

    assign take = hsel && htrans[1] && hready;
    assign mapped = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);
    assign status = '{released: pmic_reset_out_n,
        cpu_domain_reset_out: in_sync[5], cpu_power_request: in_sync[4],
        main_power_request: in_sync[3], auto_turn_on: auto_on,
        nvm_intact: nvm_ok, input_ok: vin_ok, state: state};

    // Software rail requests; a write in its data phase lands here.
    assign next_ctrl = (dp_write && dp_addr == 32'(pds_pkg::REG_CTRL))
        ? (hwdata[pds_pkg::N_RAILS-1:0] & pds_pkg::SW_MASK) : ctrl;

    // Reads see next_ctrl, so a read straight after a write is current.
    assign rd_val = !mapped ? 32'h00000000
        : (haddr[3:0] == pds_pkg::REG_CTRL) ? 32'(next_ctrl)
        : (haddr[3:0] == pds_pkg::REG_STATUS) ? 32'(status)
        : (haddr[3:0] == pds_pkg::REG_RAILS) ? 32'(rail_en)
        : (haddr[3:0] == pds_pkg::REG_DISCH) ? 32'(discharge_en)
        : 32'h00000000;

    // Bus state lives on the bus reset, apart from the sequencer's own.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 32'h00000000;
            ctrl <= pds_pkg::CTRL_RESET;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dp_write <= take && hwrite && mapped;
            dp_addr <= haddr;
            ctrl <= next_ctrl;
            hrdata <= (take && !hwrite) ? rd_val : 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!seq_rst_n);

    sequence up_entered;
        state == pds_pkg::S_UP1 && $past(state) == pds_pkg::S_WAIT;
    endsequence

    sequence run_entered;
        state == pds_pkg::S_RUN && $past(state) == pds_pkg::S_UP5;
    endsequence

    a_down_reset_low: assert property (
        $rose(state == pds_pkg::S_DOWN0)
        |-> !pmic_reset_out_n && $past(!vin_ok))
        else $error("Power-down began without reset asserted.");
    a_step0_rails_off: assert property (state == pds_pkg::S_DOWN0
        |-> (rail_en & pds_pkg::SW_MASK) == '0)
        else $error("Shutdown step left a memory or SD rail on.");
    a_usb_off_step: assert property (state == pds_pkg::S_DOWN5
        |-> !rail_en[pds_pkg::RAIL_USB] && $past(state) inside
        {pds_pkg::S_DOWN0, pds_pkg::S_DOWN5})
        else $error("USB step out of order or USB still on.");
    a_load_all_off: assert property (state == pds_pkg::S_LOAD
        |-> rail_en == '0 && discharge_en == '0)
        else $error("Rails or discharge active during load.");
    a_check_gate: assert property ((state == pds_pkg::S_CHECK
        && $past(state) == pds_pkg::S_LOAD) |-> $past(nvm_ok && auto_on))
        else $error("Check entered without integrity or turn-on.");
    a_check_disch: assert property (state == pds_pkg::S_CHECK
        |-> discharge_en == '1)
        else $error("Discharge not enabled on every rail in check.");
    a_up_needs_vin: assert property (up_entered |-> $past(vin_ok)
        ##0 rail_en == pds_pkg::STEP1_MASK)
        else $error("Power-up started without input-ok.");
    a_reset_held_up: assert property (state inside {pds_pkg::S_UP1,
        pds_pkg::S_UP2, pds_pkg::S_UP3, pds_pkg::S_UP4, pds_pkg::S_UP5}
        |-> !pmic_reset_out_n)
        else $error("Reset released during power-up.");
    a_release_end: assert property (run_entered |-> pmic_reset_out_n
        && rail_en[pds_pkg::RAIL_USB] && $past(step_done))
        else $error("Reset not released at the end of step five.");
endmodule : pds_sequencer

/* rtl/pds_pkg.sv */
// Shared constants, rail layout, register map and types of the sequencer.
package pds_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RANK_TIME_US = 1500;
    localparam int LOAD_TIME_US = 3000;
    localparam int CHECK_TIME_US = 3000;
    localparam int RANK_CYCLES = (RANK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int LOAD_CYCLES = (LOAD_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CHECK_CYCLES = (CHECK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;
    typedef logic [TIMER_W-1:0] pds_count_t;

    // ------------------------------------------------------------------
    // Rail bit positions and rank masks
    // ------------------------------------------------------------------
    localparam int N_RAILS = 15;
    typedef logic [N_RAILS-1:0] pds_rails_t;
    localparam int RAIL_CPU = 0;
    localparam int RAIL_CORE = 1;
    localparam int RAIL_GFX = 2;
    localparam int RAIL_IO = 3;
    localparam int RAIL_AUX = 4;
    localparam int RAIL_MEM = 5;
    localparam int RAIL_GEN = 6;
    localparam int RAIL_AON = 7;
    localparam int RAIL_EMMC = 8;
    localparam int RAIL_TERM = 9;
    localparam int RAIL_USB = 10;
    localparam int RAIL_PROG = 11;
    localparam int RAIL_SDS = 12;
    localparam int RAIL_SDIO = 13;
    localparam int RAIL_REF = 14;
    localparam pds_rails_t ONE = 15'h0001;
    localparam pds_rails_t STEP1_MASK = (ONE << RAIL_IO) | (ONE << RAIL_AON);
    localparam pds_rails_t STEP2_MASK = STEP1_MASK | (ONE << RAIL_CORE);
    localparam pds_rails_t STEP3_MASK =
        STEP2_MASK | (ONE << RAIL_CPU) | (ONE << RAIL_AUX);
    localparam pds_rails_t STEP4_MASK =
        STEP3_MASK | (ONE << RAIL_GEN) | (ONE << RAIL_EMMC);
    localparam pds_rails_t STEP5_MASK = STEP4_MASK | (ONE << RAIL_USB);
    // Rails that software owns while running; cut together at shutdown.
    localparam pds_rails_t SW_MASK = (ONE << RAIL_GFX) | (ONE << RAIL_SDS)
        | (ONE << RAIL_SDIO) | (ONE << RAIL_PROG) | (ONE << RAIL_MEM)
        | (ONE << RAIL_TERM) | (ONE << RAIL_REF);

    // ------------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RAILS = 4'h8;
    localparam logic [3:0] REG_DISCH = 4'hc;
    localparam pds_rails_t CTRL_RESET = 15'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        S_LOAD, S_CHECK, S_WAIT, S_UP1, S_UP2, S_UP3, S_UP4, S_UP5, S_RUN,
        S_DOWN0, S_DOWN5, S_DOWN4, S_DOWN3, S_DOWN2, S_DOWN1, S_OFF, S_HALT
    } pds_state_t;

    typedef struct packed {
        logic released;
        logic cpu_domain_reset_out;
        logic cpu_power_request;
        logic main_power_request;
        logic auto_turn_on;
        logic nvm_intact;
        logic input_ok;
        pds_state_t state;
    } pds_status_t;

endpackage : pds_pkg

/* rtl/pds_step_timer.sv */
// Down-counter that times one sequencer step.
`timescale 1ns/1ps
module pds_step_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [W-1:0] cycles,
    // Status
    output logic done
);
    logic [W-1:0] count;

    // Loaded on the step change; done marks the step's last cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (start) begin
            count <= cycles;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    // A step of N cycles ends at the edge where the count reads one.
    assign done = (count == W'(1));
endmodule : pds_step_timer

/* verif/pds_proc_model.sv */
// Behavioural application processor facing the sequencer's pins.
`timescale 1ns/1ps
module pds_proc_model #(
    parameter int MAIN_DLY = 6,
    parameter int CPU_DLY = 4
) (
    // Clock and supplies
    input wire logic clk,
    input wire pds_pkg::pds_rails_t rail_en,
    input wire logic pmic_reset_out_n,
    // Processor pins
    output logic main_power_request,
    output logic cpu_power_request,
    output logic cpu_domain_reset_out
);
    int main_cnt = 0;
    int cpu_cnt = 0;
    wire logic io_up = rail_en[pds_pkg::RAIL_IO] & rail_en[pds_pkg::RAIL_AON];
    wire logic core_up = io_up & rail_en[pds_pkg::RAIL_CORE];
    // Without supplies the pins sit at their pull-down level.
    always_ff @(posedge clk) begin
        main_cnt <= io_up ? main_cnt + 1 : 0;
        cpu_cnt <= core_up ? cpu_cnt + 1 : 0;
        main_power_request <= io_up && main_cnt >= MAIN_DLY;
        cpu_power_request <= core_up && cpu_cnt >= CPU_DLY;
        cpu_domain_reset_out <= core_up && pmic_reset_out_n;
    end
endmodule : pds_proc_model

/* verif/test_pds_sequencer.sv */
// Self-checking bench for the input-drop and restart sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_pds_sequencer;
    // Short step counts keep the run brief; expectations use the same.
    localparam int RANK = 8;
    localparam int LOAD = 10;
    localparam int CHECK = 10;
    localparam pds_pkg::pds_rails_t UPM [5] = '{pds_pkg::STEP1_MASK,
        pds_pkg::STEP2_MASK, pds_pkg::STEP3_MASK, pds_pkg::STEP4_MASK,
        pds_pkg::STEP5_MASK};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, pmic_reset_out_n;
    logic [31:0] hrdata;
    logic input_ok = 1'b0;
    logic input_por_ok = 1'b1;
    logic nvm_intact = 1'b1;
    logic nvm_auto_turn_on = 1'b1;
    logic main_power_request, cpu_power_request, cpu_domain_reset_out;
    pds_pkg::pds_rails_t rail_en, discharge_en, sw;
    logic [31:0] d;
    int fails = 0;
    int tests_run = 0;
    int seed = 43;
    int cyc = 0;
    int last = 0;
    logic rd_pend = 1'b0;
    logic [15:0] prev = 16'h0;
    wire logic [15:0] cur = {rail_en, pmic_reset_out_n};
    logic [15:0] note_q [$];
    int gap_q [$];
    logic [31:0] rexp_q [$];
    logic [31:0] rmask_q [$];

    always #50 hclk = ~hclk;

    pds_sequencer #(.RANK_CYCLES(RANK), .LOAD_CYCLES(LOAD),
        .CHECK_CYCLES(CHECK)) i_pds_sequencer (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .input_ok(input_ok), .input_por_ok(input_por_ok),
        .nvm_intact(nvm_intact), .nvm_auto_turn_on(nvm_auto_turn_on),
        .main_power_request(main_power_request),
        .cpu_power_request(cpu_power_request),
        .cpu_domain_reset_out(cpu_domain_reset_out),
        .pmic_reset_out_n(pmic_reset_out_n), .rail_en(rail_en),
        .discharge_en(discharge_en));
    pds_proc_model i_pds_proc_model (.clk(hclk), .rail_en(rail_en),
        .pmic_reset_out_n(pmic_reset_out_n),
        .main_power_request(main_power_request),
        .cpu_power_request(cpu_power_request),
        .cpu_domain_reset_out(cpu_domain_reset_out));

    // A change on the pins consumes the oldest note; gaps catch bad timing.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (hresetn && cur !== prev) begin
            prev <= cur;
            last <= cyc;
            if (note_q.size() == 0) begin
                `CHK("unexpected pins", prev, cur)
            end else begin
                `CHK("rails and reset", note_q[0], cur)
                if (gap_q[0] != 0) begin
                    `CHK("step length", gap_q[0], cyc - last)
                end
                void'(note_q.pop_front());
                void'(gap_q.pop_front());
            end
        end
        if (rd_pend && hreadyout) begin
            `CHK("read data", rexp_q[0], hrdata & rmask_q[0])
            `CHK("response", 1'b0, hresp)
            void'(rexp_q.pop_front());
            void'(rmask_q.pop_front());
        end
    end

    task automatic note(input pds_pkg::pds_rails_t r, input logic n, int g);
        note_q.push_back({r, n});
        gap_q.push_back(g);
    endtask : note

    // One single AHB-Lite transfer; the request holds until hready.
    task automatic bus(input logic [3:0] a, input logic w, logic [31:0] v);
        @(posedge hclk);
        haddr <= {28'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= v;
        rd_pend <= ~w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_pend <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, logic [31:0] e, logic [31:0] m);
        rexp_q.push_back(e & m);
        rmask_q.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask : rd

    // Waits, bounded, until only k notes remain outstanding.
    task automatic drain(input int k);
        int n;
        n = 0;
        while (note_q.size() > k && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        `CHK("notes left", k, note_q.size())
    endtask : drain

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the expected few hundred cycles.
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (LOAD + CHECK + 8) @(posedge hclk);
        rd(pds_pkg::REG_DISCH, 32'h7fff, 32'hffffffff);
        for (int i = 0; i < 5; i++) note(UPM[i], 1'b0, (i > 0) ? RANK : 0);
        note(pds_pkg::STEP5_MASK, 1'b1, RANK);
        input_ok <= 1'b1;
        drain(0);
        repeat (4) @(posedge hclk);
        rd(pds_pkg::REG_STATUS, {20'h0, 7'h7f, pds_pkg::S_RUN},
            32'hfff);
        // Memory program rail first, then a random set of software rails that keeps it and GFX on.
        note(pds_pkg::STEP5_MASK | 15'h0800, 1'b1, 0);
        bus(pds_pkg::REG_CTRL, 1'b1, 32'h0800);
        d = $random(seed) | 32'h0804;
        sw = d[14:0] & pds_pkg::SW_MASK;
        note(pds_pkg::STEP5_MASK | sw, 1'b1, 0);
        bus(pds_pkg::REG_CTRL, 1'b1, d);
        rd(pds_pkg::REG_CTRL, {17'h0, sw}, 32'hffffffff);
        rd(pds_pkg::REG_RAILS, {17'h0, pds_pkg::STEP5_MASK | sw}, '1);
        rd(pds_pkg::REG_DISCH, {17'h0, ~(pds_pkg::STEP5_MASK | sw)},
            '1);
        bus(pds_pkg::REG_STATUS, 1'b1, 32'hffffffff);
        rd(4'h2, 32'h0, 32'hffffffff);
        drain(0);
        // Input drop while running walks the full shutdown order.
        note(pds_pkg::STEP5_MASK, 1'b0, 0);
        for (int i = 3; i >= 0; i--) note(UPM[i], 1'b0, RANK);
        note(15'h0, 1'b0, RANK);
        input_ok <= 1'b0;
        drain(0);
        // Restart from off, then lose POR in mid power-up.
        for (int i = 0; i < 3; i++) note(UPM[i], 1'b0, (i > 0) ? RANK : 0);
        note(15'h0, 1'b0, 0);
        input_ok <= 1'b1;
        drain(1);
        rd(pds_pkg::REG_STATUS, {27'h0, pds_pkg::S_UP3}, 32'hc1f);
        input_por_ok <= 1'b0;
        drain(0);
        `CHK("discharge", 15'h0, discharge_en)
        nvm_auto_turn_on <= 1'b0;
        @(posedge hclk);
        input_por_ok <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(pds_pkg::REG_STATUS, {27'h0, pds_pkg::S_LOAD}, 32'h1f);
        repeat (LOAD + 8) @(posedge hclk);
        rd(pds_pkg::REG_STATUS, {27'h0, pds_pkg::S_HALT}, 32'h1f);
        `CHK("halted rails", 15'h0, rail_en)
        summarize();
    end
endmodule : test_pds_sequencer
